// ===== hw/rrt_consts.svh
`ifndef RRT_CONSTS_SVH
`define RRT_CONSTS_SVH

// register byte offsets
`define RRT_CTRL_OFFSET 8'h00
`define RRT_STATUS_OFFSET 8'h04

// control field positions
`define RRT_CTRL_ENABLE_BIT 0
`define RRT_CTRL_SRC_BIT 1
`define RRT_CTRL_RATE_LSB 4
`define RRT_CTRL_RATE_MSB 7
`define RRT_CTRL_RESET 32'h0000_0001

// status field positions
`define RRT_STAT_REQ_BIT 0
`define RRT_STAT_MAND_BIT 1
`define RRT_STAT_RATE_LSB 8
`define RRT_STAT_RATE_MSB 11
`define RRT_STAT_CNT_LSB 16
`define RRT_STAT_CNT_MSB 25

// mandatory warning lead, in clocks before the next request
`define RRT_MAND_LEAD 10'h014

// divisors per rate-select code
`define RRT_DIV_0 10'h04D
`define RRT_DIV_1 10'h05C
`define RRT_DIV_2 10'h074
`define RRT_DIV_3 10'h07C
`define RRT_DIV_4 10'h09B
`define RRT_DIV_5 10'h0AB
`define RRT_DIV_6 10'h0BA
`define RRT_DIV_7 10'h0C2
`define RRT_DIV_8 10'h0E9
`define RRT_DIV_9 10'h0F8
`define RRT_DIV_A 10'h118
`define RRT_DIV_B 10'h136
`define RRT_DIV_C 10'h175
`define RRT_DIV_D 10'h185
`define RRT_DIV_E 10'h1FF
`define RRT_DIV_F 10'h271

`endif

// ===== hw/rrt_pkg.sv
package rrt_pkg;
  typedef logic [3:0] rrt_rate_t;
  typedef logic [9:0] rrt_count_t;
endpackage

// ===== hw/rrt_cnt_if.sv
`timescale 1ns/1ns
// link between the request logic and the period divider
interface rrt_cnt_if;
  logic clear;
  logic enable;
  rrt_pkg::rrt_rate_t rate;
  rrt_pkg::rrt_count_t count;
  logic period_end;
  logic mand_point;
  modport ctrl (output clear, output enable, output rate,
                input count, input period_end, input mand_point);
  modport div (input clear, input enable, input rate,
               output count, output period_end, output mand_point);
endinterface

// ===== hw/rrt_divider.sv
`timescale 1ns/1ns
`include "rrt_consts.svh"
module rrt_divider (
  input wire logic hclk,
  input wire logic hresetn,
  rrt_cnt_if.div cnt
);
  // ==========================================
  // divisor lookup
  rrt_pkg::rrt_count_t divisor;
  rrt_pkg::rrt_count_t count_reg;
  rrt_pkg::rrt_count_t count_next;

  always_comb begin
    case (cnt.rate)
      4'h0: divisor = `RRT_DIV_0;
      4'h1: divisor = `RRT_DIV_1;
      4'h2: divisor = `RRT_DIV_2;
      4'h3: divisor = `RRT_DIV_3;
      4'h4: divisor = `RRT_DIV_4;
      4'h5: divisor = `RRT_DIV_5;
      4'h6: divisor = `RRT_DIV_6;
      4'h7: divisor = `RRT_DIV_7;
      4'h8: divisor = `RRT_DIV_8;
      4'h9: divisor = `RRT_DIV_9;
      4'hA: divisor = `RRT_DIV_A;
      4'hB: divisor = `RRT_DIV_B;
      4'hC: divisor = `RRT_DIV_C;
      4'hD: divisor = `RRT_DIV_D;
      4'hE: divisor = `RRT_DIV_E;
      default: divisor = `RRT_DIV_F;
    endcase
  end

  // ==========================================
  // free-running period counter
  // continuous divide-by count
  always_comb begin
    count_next = count_reg;
    if (cnt.clear) begin
      count_next = 10'h000;
    end else if (cnt.enable) begin
      if (count_reg >= divisor - 10'h001) begin
        count_next = 10'h000;
      end else begin
        count_next = count_reg + 10'h001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= 10'h000;
    end else begin
      count_reg <= count_next;
    end
  end

  // period end and mandatory check point
  assign cnt.count = count_reg;
  assign cnt.period_end = cnt.enable && !cnt.clear && (count_reg >= divisor - 10'h001);
  assign cnt.mand_point = cnt.enable && !cnt.clear &&
                          (count_reg == divisor - 10'h001 - `RRT_MAND_LEAD);
endmodule

// ===== hw/rrt_timer.sv
`timescale 1ns/1ns
`include "rrt_consts.svh"
// Behaviour
// - an internal counter runs continuously and starts a new request period every divisor clocks.
// - four rate-select inputs pick one of sixteen divisors, e.g. 116, 233 and 625 clocks.
// - reaching the divisor raises the request, high on the true output and low on the inverted one.
// - the request stays active until an active level is seen on either completion input.
// - a request still active 20 clocks before the next one raises the mandatory refresh outputs.
// - a sampled active completion returns request and mandatory outputs inactive on the next edge, except that a period end in the same cycle raises the request.
// - request and mandatory outputs come in both polarities and completion has two inputs.
// - a low timer reset clears the counter and holds request and mandatory outputs inactive for as long as it stays low.
module rrt_timer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [3:0] rate_select,
  input wire logic refresh_complete,
  input wire logic refresh_complete_n,
  input wire logic timer_reset_n,
  output logic refresh_request,
  output logic refresh_request_n,
  output logic mandatory_refresh,
  output logic mandatory_refresh_n
);
  // ==========================================
  // pin synchronisers
  logic [3:0] rate_meta;
  logic [3:0] rate_sync;
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [3:0] rate_meta_next;
  logic [3:0] rate_sync_next;
  logic [2:0] pin_meta_next;
  logic [2:0] pin_sync_next;

  // next values of the two sampling stages
  always_comb begin
    rate_meta_next = rate_select;
    rate_sync_next = rate_meta;
    pin_meta_next = {timer_reset_n, refresh_complete_n, refresh_complete};
    pin_sync_next = pin_meta;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rate_meta <= 4'h0;
      rate_sync <= 4'h0;
      // idle levels: timer reset and active-low completion high
      pin_meta <= 3'h6;
      pin_sync <= 3'h6;
    end else begin
      rate_meta <= rate_meta_next;
      rate_sync <= rate_sync_next;
      pin_meta <= pin_meta_next;
      pin_sync <= pin_sync_next;
    end
  end

  logic complete_seen;
  logic timer_clear;
  // a completion held on a pin keeps clearing the flags until released
  // either input may signal completion
  assign complete_seen = pin_sync[0] || !pin_sync[1];
  assign timer_clear = !pin_sync[2];

  // ==========================================
  // bus slave
  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  logic wr_pend_reg;
  logic wr_pend_next;
  logic [7:0] wr_addr_reg;
  logic [7:0] wr_addr_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [31:0] status_word;
  logic req_reg;
  logic req_next;
  logic mand_reg;
  logic mand_next;
  rrt_pkg::rrt_rate_t rate_used;
  logic addr_phase;
  logic read_taken;
  logic ctrl_write;

  // link to the period divider
  rrt_cnt_if cnt ();

  // transfer taken, and its kind
  assign addr_phase = hsel && htrans[1] && hready;
  assign read_taken = addr_phase && !hwrite;
  assign ctrl_write = wr_pend_reg && (wr_addr_reg == `RRT_CTRL_OFFSET);
  // register code overrides the pins when src is set
  assign rate_used = ctrl_reg[`RRT_CTRL_SRC_BIT] ? ctrl_reg[`RRT_CTRL_RATE_MSB:`RRT_CTRL_RATE_LSB]
                                                  : rate_sync;

  // status word assembly
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`RRT_STAT_REQ_BIT] = req_reg;
    status_word[`RRT_STAT_MAND_BIT] = mand_reg;
    status_word[`RRT_STAT_RATE_MSB:`RRT_STAT_RATE_LSB] = rate_used;
    status_word[`RRT_STAT_CNT_MSB:`RRT_STAT_CNT_LSB] = cnt.count;
  end

  // address capture, write in data phase, read data registered
  always_comb begin
    wr_pend_next = addr_phase && hwrite;
    wr_addr_next = addr_phase ? haddr[7:0] : wr_addr_reg;
    rdata_next = rdata_reg;
    ctrl_next = ctrl_reg;
    if (read_taken) begin
      case (haddr[7:0])
        `RRT_CTRL_OFFSET: rdata_next = ctrl_reg;
        `RRT_STATUS_OFFSET: rdata_next = status_word;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
    if (ctrl_write) begin
      ctrl_next = 32'h0000_0000;
      ctrl_next[`RRT_CTRL_ENABLE_BIT] = hwdata[`RRT_CTRL_ENABLE_BIT];
      ctrl_next[`RRT_CTRL_SRC_BIT] = hwdata[`RRT_CTRL_SRC_BIT];
      ctrl_next[`RRT_CTRL_RATE_MSB:`RRT_CTRL_RATE_LSB] =
        hwdata[`RRT_CTRL_RATE_MSB:`RRT_CTRL_RATE_LSB];
    end
  end

  // bus registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= `RRT_CTRL_RESET;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      rdata_reg <= rdata_next;
      // zero wait states from the first edge after reset
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign hrdata = rdata_reg;

  // ==========================================
  // period divider
  // timer reset clears counter
  assign cnt.clear = timer_clear;
  assign cnt.enable = ctrl_reg[`RRT_CTRL_ENABLE_BIT];
  assign cnt.rate = rate_used;

  rrt_divider u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .cnt(cnt.div)
  );

  // ==========================================
  // request and mandatory flags
  always_comb begin
    req_next = req_reg;
    mand_next = mand_reg;
    if (timer_clear) begin
      req_next = 1'b0;
      mand_next = 1'b0;
    end else begin
      if (complete_seen) begin
        req_next = 1'b0;
        mand_next = 1'b0;
      end
      // a period end in the same cycle wins over the completion
      // request held until completion
      if (cnt.period_end) begin
        req_next = 1'b1;
      end
      if (cnt.mand_point && req_reg && !complete_seen) begin
        mand_next = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_reg <= 1'b0;
      mand_reg <= 1'b0;
      refresh_request <= 1'b0;
      refresh_request_n <= 1'b1;
      mandatory_refresh <= 1'b0;
      mandatory_refresh_n <= 1'b1;
    end else begin
      req_reg <= req_next;
      mand_reg <= mand_next;
      refresh_request <= req_next;
      refresh_request_n <= !req_next;
      mandatory_refresh <= mand_next;
      mandatory_refresh_n <= !mand_next;
    end
  end
endmodule

// ===== verification/rrt_timer_checker.sv
`timescale 1ns/1ns
// ========================================
// port checker
module rrt_timer_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hresp,
  input wire logic hreadyout,
  input wire logic refresh_complete,
  input wire logic refresh_complete_n,
  input wire logic timer_reset_n,
  input wire logic refresh_request,
  input wire logic refresh_request_n,
  input wire logic mandatory_refresh,
  input wire logic mandatory_refresh_n
);
  // any clearing cause at the pins
  wire clr = refresh_complete | !refresh_complete_n | !timer_reset_n;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  chk_ready_after_rst: assert property ($past(hresetn) |-> hreadyout)
    else $error("wait state inserted");
  chk_req_polarity: assert property (refresh_request_n == !refresh_request)
    else $error("request pair disagrees");
  chk_mand_polarity: assert property (mandatory_refresh_n == !mandatory_refresh)
    else $error("mandatory pair disagrees");
  chk_req_holds: assert property ($fell(refresh_request) |-> $past(clr, 3))
    else $error("request dropped without cause");
  chk_mand_lead: assert property ($rose(mandatory_refresh) |-> $past(refresh_request, 20))
    else $error("mandatory without pending request");
  chk_comp_clears: assert property (clr [*4] |=> !mandatory_refresh)
    else $error("mandatory not cleared");
  chk_treset_clears: assert property (!timer_reset_n [*4] |=> !refresh_request)
    else $error("request during timer reset");
  chk_mand_with_req: assert property ($rose(mandatory_refresh) |-> refresh_request)
    else $error("mandatory without active request");
  cover property ($fell(refresh_complete_n));
  cover property ($rose(refresh_request));
  cover property ($rose(mandatory_refresh));
  cover property ($fell(refresh_request));
endmodule

bind rrt_timer rrt_timer_checker chk (.hclk, .hresetn, .hresp, .hreadyout, .refresh_complete,
  .refresh_complete_n, .timer_reset_n, .refresh_request, .refresh_request_n,
  .mandatory_refresh, .mandatory_refresh_n);

// ===== verification/rrt_mem_ctrl.sv
`timescale 1ns/1ns
// ========================================
// memory timing controller model
module rrt_mem_ctrl (
  input wire logic hclk,
  input wire logic en,
  input wire logic use_low,
  input wire logic [7:0] lag,
  input wire logic refresh_request,
  input wire logic mandatory_refresh,
  output logic refresh_complete,
  output logic refresh_complete_n
);
  // answer a request after lag clocks
  initial begin
    refresh_complete = 1'b0;
    refresh_complete_n = 1'b1;
    forever begin
      @(posedge hclk);
      if (en && (refresh_request === 1'b1 || mandatory_refresh === 1'b1)) begin
        repeat (lag) @(posedge hclk);
        refresh_complete <= !use_low;
        refresh_complete_n <= !use_low;
        @(posedge hclk);
        while (refresh_request === 1'b1) @(posedge hclk);
        refresh_complete <= 1'b0;
        refresh_complete_n <= 1'b1;
      end
    end
  end
endmodule

// ===== verification/dram_refresh_request_timer_tb.sv
`timescale 1ns/1ns
// ========================================
// bench top
module dram_refresh_request_timer_tb;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic timer_reset_n = 1'b1, pen = 1'b0, plow = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] rate_select = 4'h0;
  logic [7:0] lag = 8'h00;
  wire logic hready, hreadyout, hresp, refresh_complete, refresh_complete_n;
  wire logic refresh_request, refresh_request_n, mandatory_refresh, mandatory_refresh_n;
  wire logic [31:0] hrdata;
  int failures = 0, samples_checked = 0, n, m;
  int divs[16] = '{77, 92, 116, 124, 155, 171, 186, 194, 233, 248, 280, 310, 373, 389, 511, 625};
  // clock and single-slave ready
  always #20 hclk = ~hclk;
  assign hready = hreadyout;
  rrt_timer dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .rate_select, .refresh_complete, .refresh_complete_n,
    .timer_reset_n, .refresh_request, .refresh_request_n, .mandatory_refresh,
    .mandatory_refresh_n);
  rrt_mem_ctrl partner (.hclk, .en(pen), .use_low(plow), .lag, .refresh_request,
    .mandatory_refresh, .refresh_complete, .refresh_complete_n);
  // ========================================
  // tasks
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task rise(output int c);
    c = 0;
    while (refresh_request !== 1'b0) begin
      @(posedge hclk);
      c++;
    end
    while (refresh_request !== 1'b1) begin
      @(posedge hclk);
      c++;
    end
  endtask
  task treset;
    timer_reset_n <= 1'b0;
    repeat (4) @(posedge hclk);
    timer_reset_n <= 1'b1;
  endtask
  task wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (60000) @(posedge hclk);
    failures++;
    wrap_up;
  end
  // ========================================
  // main sequence
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, 32'h0, 32'h0, rd);
    chk("ctrl_reset", rd, 32'h1);
    ahb(1'b0, 32'h8, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    // every rate code, both completion polarities
    pen <= 1'b1;
    for (int c = 0; c < 16; c++) begin
      rate_select <= c[3:0];
      plow <= c[0];
      treset;
      rise(n);
      rise(n);
      chk("period", 32'(n), 32'(divs[c]));
    end
    $display("rate table done");
    // unanswered request turns mandatory
    pen <= 1'b0;
    rate_select <= 4'h0;
    treset;
    rise(n);
    m = 0;
    while (mandatory_refresh !== 1'b1) begin
      @(posedge hclk);
      m++;
    end
    chk("mand_lead", 32'(m), 32'(77 - 20));
    chk("req_held", {28'h0, refresh_request, refresh_request_n, 2'h0}, 32'h8);
    lag <= 8'h05;
    pen <= 1'b1;
    repeat (14) @(posedge hclk);
    chk("cleared", {28'h0, refresh_request, refresh_request_n, mandatory_refresh,
      mandatory_refresh_n}, 32'h5);
    $display("mandatory done");
    // rate from the control register
    ahb(1'b1, 32'h0, 32'hF3, rd);
    ahb(1'b0, 32'h4, 32'h0, rd);
    chk("rate_in_use", {28'h0, rd[11:8]}, 32'hF);
    $display("register rate done");
    // second reset in mid-run
    hresetn <= 1'b0;
    @(posedge hclk);
    @(negedge hclk);
    chk("rst_outs", {27'h0, hreadyout, refresh_request, refresh_request_n, mandatory_refresh,
      mandatory_refresh_n}, 32'h5);
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, 32'h0, 32'h0, rd);
    chk("ctrl_again", rd, 32'h1);
    $display("reset done");
    // disabled counter stays frozen at zero after a timer reset
    ahb(1'b1, 32'h0, 32'h0, rd);
    treset;
    repeat (100) @(posedge hclk);
    ahb(1'b0, 32'h4, 32'h0, rd);
    chk("frozen_count", {22'h0, rd[25:16]}, 32'h0);
    chk("no_request", {31'h0, refresh_request}, 32'h0);
    $display("disable done");
    wrap_up;
  end
endmodule
